//--- scfm_map.svh
// constants for the serial flash configuration master
`ifndef SCFM_MAP_SVH
`define SCFM_MAP_SVH

// ----------------------------------------
// clocking
// ----------------------------------------
`define SCFM_REF_PERIOD_NS      50
`define SCFM_CLK_TARGET_NS      25
`define SCFM_CLK_MIN_MHZ        15
`define SCFM_CLK_TYP_MHZ        25
`define SCFM_CLK_MAX_MHZ        40
// half period of the serial clock in reference cycles, rounded up, at least one
`define SCFM_HALF_CYC_RAW       (((`SCFM_CLK_TARGET_NS / 2) + `SCFM_REF_PERIOD_NS - 1) / `SCFM_REF_PERIOD_NS)
`define SCFM_HALF_CYC           ((`SCFM_HALF_CYC_RAW < 1) ? 1 : `SCFM_HALF_CYC_RAW)

// ----------------------------------------
// delays
// ----------------------------------------
`define SCFM_STATUS_MAX_US      100
`define SCFM_STATUS_DLY_US      40
`define SCFM_STATUS_DLY_CYC     ((`SCFM_STATUS_DLY_US * 1000) / `SCFM_REF_PERIOD_NS)
`define SCFM_USER_MIN_US        20
`define SCFM_USER_MAX_US        100
`define SCFM_USER_DLY_CYC       (((`SCFM_USER_MIN_US * 1000) + `SCFM_REF_PERIOD_NS - 1) / `SCFM_REF_PERIOD_NS)
`define SCFM_SEL_PULSE_CYC      16'h0004
`define SCFM_DATA_SETUP_NS      7

// ----------------------------------------
// flash command
// ----------------------------------------
`define SCFM_READ_CMD           8'h03
`define SCFM_CMD_BITS           6'h1F
// extra command falls that cover the pin synchroniser delay; fits a one-cycle half period only
`define SCFM_SYNC_LAG_FALLS     6'h02
`define SCFM_STREAM_BITS        32'h0100_0000

`endif

//--- scfm_pkg.sv
// types for the serial flash configuration master
package scfm_pkg;

    typedef enum logic [2:0] {
        SCFM_RESET  = 3'b000,
        SCFM_CMD    = 3'b001,
        SCFM_LOAD   = 3'b011,
        SCFM_EXPAND = 3'b010,
        SCFM_WAIT   = 3'b110,
        SCFM_INIT   = 3'b111,
        SCFM_USER   = 3'b101,
        SCFM_ERROR  = 3'b100
    } scfm_state_t;

    typedef struct packed {
        logic clk;
        logic clkOe;
        logic select_n;
        logic selectOe;
        logic cmd;
        logic cmdOe;
    } scfm_flash_out_t;

    typedef struct packed {
        scfm_state_t state;
        logic [7:0]  div;
        logic        clk;
        logic [31:0] bitCnt;
        logic [5:0]  cmdCnt;
        logic [31:0] cmdSh;
        logic [7:0]  tok;
        logic [2:0]  tokCnt;
        logic [7:0]  expCnt;
        logic        expRun;
        logic [15:0] dly;
        logic        select_n;
        logic        pinOe;
        logic        cmd;
        logic        statusOe;
        logic        completeOe;
        logic        userMode;
        logic        outBit;
        logic        outValid;
        logic        bridgeData;
    } scfm_regs_t;

endpackage

//--- scfm_sync.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module scfm_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // raw and filtered levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            dout <= RST;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // per bit: only a level seen on two stages counts
            dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
        end
    end

endmodule // scfm_sync
`default_nettype wire

//--- scfm_config_master.sv
// active serial configuration master: flash read, expansion, handshakes
`timescale 1ns/1ps
`default_nettype none
`include "scfm_map.svh"

// Notes on behaviour
// - serial clock derived from own oscillator
// - serial clock targets 40 MHz, 25 ns
// - one configuration bit per serial clock
// - serial clock runs at 10 MHz, below the 15..40 MHz range
// - status released within 100 us of request
// - data sampled at serial clock falling edge
// - user mode 20..100 us after completion
// - low request holds device in reset
// - compressed stream expanded internally
// - user mode bridges boundary-scan to flash
// - error restart: select pulse, status release, retry
module scfm_config_master #(
    parameter logic [31:0] STREAM_BITS = `SCFM_STREAM_BITS
) (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    // configuration handshake pins
    input  wire logic                      configRequest_n,
    input  wire logic                      chipEnableIn_n,
    input  wire logic                      configCompleteIn,
    output logic                           configCompleteOut,
    output logic                           configCompleteOe,
    output logic                           statusOut,
    output logic                           statusOe,
    // serial flash pins
    input  wire logic                      flashDataIn,
    output scfm_pkg::scfm_flash_out_t      flashOut,
    // core options and error report
    input  wire logic                      compressEn,
    input  wire logic                      autoRestartEn,
    input  wire logic                      frameError,
    // expanded bitstream to the core
    output logic                           streamBit,
    output logic                           streamValid,
    output logic                           userMode,
    // boundary-scan bridge
    input  wire logic                      bridgeEn,
    input  wire logic                      bridgeClk,
    input  wire logic                      bridgeSelect_n,
    input  wire logic                      bridgeCmd,
    output logic                           bridgeData
);

    localparam logic [7:0]  HALF_LAST   = 8'(`SCFM_HALF_CYC - 1);
    localparam logic [15:0] STATUS_LAST = 16'(`SCFM_STATUS_DLY_CYC - 1);
    localparam logic [15:0] USER_LAST   = 16'(`SCFM_USER_DLY_CYC - 1);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [3:0] pinRaw;
    logic [3:0] pinSync;
    logic       reqHigh;
    logic       ceHigh;
    logic       dataS;
    logic       completeS;

    assign pinRaw = {configRequest_n, chipEnableIn_n, flashDataIn, configCompleteIn};

    scfm_sync #(
        .W   (4),
        .RST (4'b0100)
    ) u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .din     (pinRaw),
        .dout    (pinSync)
    );

    assign reqHigh   = pinSync[3];
    assign ceHigh    = pinSync[2];
    assign dataS     = pinSync[1];
    assign completeS = pinSync[0];

    // ----------------------------------------
    // state
    // ----------------------------------------
    scfm_pkg::scfm_regs_t r_r;
    scfm_pkg::scfm_regs_t r_nxt;
    logic                 tick;
    logic                 fall;
    logic [7:0]           newTok;

    always_comb begin
        r_nxt          = r_r;
        r_nxt.outValid = 1'b0;
        tick           = 1'b0;
        newTok         = {dataS, r_r.tok[7:1]};
        // serial clock from the reference divider; halted outside transfers
        if (r_r.state == scfm_pkg::SCFM_CMD || r_r.state == scfm_pkg::SCFM_LOAD) begin
            if (r_r.div == HALF_LAST) begin
                r_nxt.div = 8'h00;
                r_nxt.clk = ~r_r.clk;
                tick      = 1'b1;
            end else begin
                r_nxt.div = r_r.div + 8'h01;
            end
        end else if (r_r.state != scfm_pkg::SCFM_USER) begin
            r_nxt.div = 8'h00;
            r_nxt.clk = 1'b0;
        end
        fall = tick & r_r.clk;

        case (r_r.state)
            scfm_pkg::SCFM_RESET: begin
                r_nxt.statusOe   = 1'b1;
                r_nxt.completeOe = 1'b1;
                r_nxt.userMode   = 1'b0;
                r_nxt.select_n   = 1'b1;
                r_nxt.bitCnt     = 32'h0000_0000;
                r_nxt.tokCnt     = 3'h0;
                if (reqHigh && !ceHigh) begin
                    r_nxt.state    = scfm_pkg::SCFM_CMD;
                    r_nxt.statusOe = 1'b0;
                    r_nxt.select_n = 1'b0;
                    r_nxt.cmdSh    = {`SCFM_READ_CMD, 24'h00_0000};
                    r_nxt.cmd      = 1'(`SCFM_READ_CMD >> 7);
                    r_nxt.cmdCnt   = 6'h00;
                end
            end
            scfm_pkg::SCFM_CMD: begin
                if (fall) begin
                    // first data bit reaches dataS only after these extra falls
                    if (r_r.cmdCnt == `SCFM_CMD_BITS + `SCFM_SYNC_LAG_FALLS) begin
                        r_nxt.state = scfm_pkg::SCFM_LOAD;
                    end else begin
                        r_nxt.cmdSh  = {r_r.cmdSh[30:0], 1'b0};
                        r_nxt.cmd    = r_r.cmdSh[30];
                        r_nxt.cmdCnt = r_r.cmdCnt + 6'h01;
                    end
                end
            end
            scfm_pkg::SCFM_LOAD: begin
                if (fall) begin
                    r_nxt.bitCnt = r_r.bitCnt + 32'h0000_0001;
                    if (!compressEn) begin
                        r_nxt.outBit   = dataS;
                        r_nxt.outValid = 1'b1;
                        if (r_nxt.bitCnt == STREAM_BITS) begin
                            r_nxt.state = scfm_pkg::SCFM_WAIT;
                        end
                    end else begin
                        r_nxt.tok    = newTok;
                        r_nxt.tokCnt = r_r.tokCnt + 3'h1;
                        if (r_r.tokCnt == 3'h7) begin
                            // token: msb set is a zero run, else seven literal bits
                            r_nxt.state  = scfm_pkg::SCFM_EXPAND;
                            r_nxt.expRun = newTok[7];
                            r_nxt.expCnt = newTok[7] ? {1'b0, newTok[6:0]} : 8'h06;
                        end
                    end
                end
            end
            scfm_pkg::SCFM_EXPAND: begin
                // flash clock pauses here; long runs stall the read
                r_nxt.outValid = 1'b1;
                r_nxt.outBit   = r_r.expRun ? 1'b0 : r_r.tok[0];
                r_nxt.tok      = {1'b0, r_r.tok[7:1]};
                if (r_r.expCnt == 8'h00) begin
                    r_nxt.state = (r_r.bitCnt >= STREAM_BITS) ? scfm_pkg::SCFM_WAIT
                                                              : scfm_pkg::SCFM_LOAD;
                end else begin
                    r_nxt.expCnt = r_r.expCnt - 8'h01;
                end
            end
            scfm_pkg::SCFM_WAIT: begin
                r_nxt.select_n   = 1'b1;
                r_nxt.completeOe = 1'b0;
                r_nxt.dly        = 16'h0000;
                if (completeS) begin
                    r_nxt.state = scfm_pkg::SCFM_INIT;
                end
            end
            scfm_pkg::SCFM_INIT: begin
                r_nxt.dly = r_r.dly + 16'h0001;
                if (r_r.dly == USER_LAST) begin
                    r_nxt.state    = scfm_pkg::SCFM_USER;
                    r_nxt.userMode = 1'b1;
                end
            end
            scfm_pkg::SCFM_USER: begin
                // flash is free for the boundary-scan bridge
                if (bridgeEn) begin
                    r_nxt.clk        = bridgeClk;
                    r_nxt.select_n   = bridgeSelect_n;
                    r_nxt.cmd        = bridgeCmd;
                    r_nxt.bridgeData = dataS;
                end else begin
                    r_nxt.clk      = 1'b0;
                    r_nxt.select_n = 1'b1;
                end
            end
            scfm_pkg::SCFM_ERROR: begin
                r_nxt.statusOe = 1'b1;
                r_nxt.dly      = r_r.dly + 16'h0001;
                // short select pulse resets the flash read sequence
                r_nxt.select_n = (r_r.dly < `SCFM_SEL_PULSE_CYC) ? 1'b0 : 1'b1;
                if (r_r.dly >= STATUS_LAST) begin
                    r_nxt.dly = STATUS_LAST;
                    if (autoRestartEn) begin
                        r_nxt.state = scfm_pkg::SCFM_RESET;
                    end
                end
            end
            default: begin
                r_nxt.state = scfm_pkg::SCFM_RESET;
            end
        endcase

        if (frameError && (r_r.state == scfm_pkg::SCFM_LOAD ||
                           r_r.state == scfm_pkg::SCFM_EXPAND ||
                           r_r.state == scfm_pkg::SCFM_WAIT)) begin
            r_nxt.state      = scfm_pkg::SCFM_ERROR;
            r_nxt.dly        = 16'h0000;
            r_nxt.completeOe = 1'b1;
            r_nxt.statusOe   = 1'b1;
        end
        if (!reqHigh) begin
            r_nxt.state = scfm_pkg::SCFM_RESET;
            r_nxt.statusOe   = 1'b1;
            r_nxt.completeOe = 1'b1;
            r_nxt.userMode   = 1'b0;
            r_nxt.select_n   = 1'b1;
        end
        // never fight an external programmer on the flash pins
        r_nxt.pinOe = ~ceHigh;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_r            <= '0;
            r_r.state      <= scfm_pkg::SCFM_RESET;
            r_r.select_n   <= 1'b1;
            r_r.statusOe   <= 1'b1;
            r_r.completeOe <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------
    // outputs from the state register; status and completion levels tied low
    // ----------------------------------------
    assign flashOut = '{clk:      r_r.clk,
                        clkOe:    r_r.pinOe,
                        select_n: r_r.select_n,
                        selectOe: r_r.pinOe,
                        cmd:      r_r.cmd,
                        cmdOe:    r_r.pinOe};

    assign configCompleteOut = 1'b0;
    assign configCompleteOe  = r_r.completeOe;
    assign statusOut         = 1'b0;
    assign statusOe          = r_r.statusOe;
    assign streamBit         = r_r.outBit;
    assign streamValid       = r_r.outValid;
    assign userMode          = r_r.userMode;
    assign bridgeData        = r_r.bridgeData;

endmodule // scfm_config_master
`default_nettype wire

//--- scfm_checker.sv
// assertions on the configuration master pins
`timescale 1ns/1ps
`default_nettype none
module scfm_checker #(
    parameter logic [31:0] STREAM_BITS = 32'h0100_0000
) (
    // clock and reset
    input wire logic                      ref_clk,
    input wire logic                      arst_n,
    // handshake pins
    input wire logic                      configRequest_n,
    input wire logic                      chipEnableIn_n,
    input wire logic                      configCompleteIn,
    input wire logic                      configCompleteOe,
    input wire logic                      statusOe,
    // flash side and options
    input wire scfm_pkg::scfm_flash_out_t flashOut,
    input wire logic                      compressEn,
    input wire logic                      autoRestartEn,
    // core and bridge
    input wire logic                      streamValid,
    input wire logic                      userMode,
    input wire logic                      bridgeEn,
    input wire logic                      bridgeSelect_n
);
    logic [11:0] doneHi_r;
    logic [11:0] statHi_r;
    // saturating counts of completion line high and of status held during a run
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            doneHi_r <= 12'h000;
            statHi_r <= 12'h000;
        end else begin
            doneHi_r <= !configCompleteIn ? 12'h000 : doneHi_r + {11'h000, doneHi_r != 12'hFFF};
            statHi_r <= !(statusOe && configRequest_n && !chipEnableIn_n) ? 12'h000
                        : statHi_r + {11'h000, statHi_r != 12'hFFF};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    pins_released_a: assert property (chipEnableIn_n [*6] |->
        !(flashOut.clkOe || flashOut.selectOe || flashOut.cmdOe)) else $error("flash pins driven");
    clock_framed_a: assert property ($changed(flashOut.clk) && !userMode |->
        !flashOut.select_n) else $error("serial clock outside frame");
    clock_rate_a: assert property ($rose(flashOut.clk) && !userMode && !compressEn |=>
        !flashOut.clk) else $error("serial clock high too long");
    one_bit_a: assert property (streamValid && !compressEn |=> !streamValid)
        else $error("two bits in one serial cycle");
    status_release_a: assert property ($rose(configRequest_n) && !chipEnableIn_n
        ##1 (configRequest_n && !chipEnableIn_n) [*7] |-> !statusOe) else $error("status held");
    reset_hold_a: assert property (!configRequest_n [*6] |->
        statusOe && configCompleteOe && !userMode) else $error("not held in reset");
    user_delay_a: assert property ($rose(userMode) |->
        doneHi_r >= 12'h190 && doneHi_r <= 12'h7D0) else $error("user mode delay");
    done_first_a: assert property (userMode |-> !configCompleteOe)
        else $error("user mode with completion held");
    status_retry_a: assert property (autoRestartEn |-> statHi_r <= 12'h7D0)
        else $error("status not released after error");
    select_pulse_a: assert property ($rose(statusOe) && $past(configRequest_n)
        && configRequest_n |-> !flashOut.select_n ##[3:5] flashOut.select_n)
        else $error("no select pulse");
    bridge_copy_a: assert property (userMode && bridgeEn && $past(userMode && bridgeEn) |->
        flashOut.select_n == $past(bridgeSelect_n)) else $error("bridge select not copied");
    cover property ($rose(userMode));
    cover property (streamValid && compressEn);
    cover property ($fell(statusOe) && autoRestartEn && configRequest_n);
endmodule // scfm_checker
bind scfm_config_master scfm_checker #(.STREAM_BITS(STREAM_BITS)) scfm_checker_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .configRequest_n(configRequest_n),
    .chipEnableIn_n(chipEnableIn_n), .configCompleteIn(configCompleteIn),
    .configCompleteOe(configCompleteOe), .statusOe(statusOe), .flashOut(flashOut),
    .compressEn(compressEn), .autoRestartEn(autoRestartEn), .streamValid(streamValid),
    .userMode(userMode), .bridgeEn(bridgeEn), .bridgeSelect_n(bridgeSelect_n));
`default_nettype wire

//--- scfm_flash_model.sv
// behavioural serial configuration flash
`timescale 1ns/1ps
`default_nettype none
module scfm_flash_model (
    // flash pins
    input  wire logic fClk,
    input  wire logic fSel_n,
    input  wire logic fCmd,
    output logic      fData
);
    logic        mem [0:1023];
    logic [31:0] cmdSh = 32'h0000_0000;
    int          rises = 0;
    int          idx   = 0;
    initial fData = 1'b0;
    always @(posedge fClk) begin
        if (!fSel_n && rises < 32) begin
            cmdSh = {cmdSh[30:0], fCmd};
            rises = rises + 1;
        end
    end
    // released line shows the inverse, never a stale bit
    always @(negedge fClk or posedge fSel_n) begin
        if (fSel_n) begin
            rises = 0;
            idx = 0;
            fData = ~mem[0];
        end else if (rises >= 32) begin
            fData = mem[idx];
            idx = idx + 1;
        end
    end
endmodule // scfm_flash_model
`default_nettype wire

//--- scfm_config_master_tb.sv
// self-checking bench for the configuration master
`timescale 1ns/1ps
`default_nettype none
module scfm_config_master_tb;
    localparam logic [31:0] NBITS = 32'h0000_0040;
    logic ref_clk = 1'b0, arst_n = 1'b0, configRequest_n = 1'b0, chipEnableIn_n = 1'b0;
    logic compressEn = 1'b0, autoRestartEn = 1'b0, frameError = 1'b0, bridgeEn = 1'b0;
    logic bridgeClk = 1'b0, bridgeSelect_n = 1'b1, bridgeCmd = 1'b0;
    logic configCompleteOut, configCompleteOe, statusOut, statusOe, flashDataIn;
    logic streamBit, streamValid, userMode, bridgeData;
    scfm_pkg::scfm_flash_out_t flashOut;
    int   miscompares = 0;
    int   checks      = 0;
    logic got [$];
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (streamValid === 1'b1) got.push_back(streamBit);
    scfm_config_master #(.STREAM_BITS(NBITS)) scfm_config_master_i (.ref_clk(ref_clk),
        .arst_n(arst_n), .configRequest_n(configRequest_n), .chipEnableIn_n(chipEnableIn_n),
        .configCompleteIn(!configCompleteOe), .configCompleteOut(configCompleteOut),
        .configCompleteOe(configCompleteOe), .statusOut(statusOut), .statusOe(statusOe),
        .flashDataIn(flashDataIn), .flashOut(flashOut), .compressEn(compressEn),
        .autoRestartEn(autoRestartEn), .frameError(frameError), .streamBit(streamBit),
        .streamValid(streamValid), .userMode(userMode), .bridgeEn(bridgeEn),
        .bridgeClk(bridgeClk), .bridgeSelect_n(bridgeSelect_n), .bridgeCmd(bridgeCmd),
        .bridgeData(bridgeData));
    // select has a board pull-up, clock a pull-down
    scfm_flash_model fm (.fClk(flashOut.clkOe & flashOut.clk),
        .fSel_n(!flashOut.selectOe | flashOut.select_n), .fCmd(flashOut.cmd), .fData(flashDataIn));
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input logic a, input logic b, input string m);
        checks++;
        if (a !== b) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic waitv(ref logic s, input logic v, input int lim);
        int n = 0;
        while (s !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk(n < lim, 1'b1, "timeout");
        if (n >= lim) end_of_test();
    endtask
    // what the core should see, sampling from offset 0 or one idle bit late
    function automatic void model(input int off, input logic cmp, ref logic q[$]);
        logic s [$];
        logic [7:0] t;
        q.delete();
        for (int k = 0; k < NBITS; k++) s.push_back(k < off ? ~fm.mem[0] : fm.mem[k - off]);
        for (int k = 0; k < NBITS; k++) begin
            if (!cmp) q.push_back(s[k]);
            else if (k % 8 == 7) begin
                for (int j = 0; j < 8; j++) t[j] = s[k - 7 + j];
                if (!t[7]) for (int j = 0; j < 7; j++) q.push_back(t[j]);
                else for (int j = 0; j <= t[6:0]; j++) q.push_back(1'b0);
            end
        end
    endfunction
    function automatic bit same(ref logic a[$], ref logic b[$]);
        if (a.size() != b.size()) return 1'b0;
        foreach (a[i]) if (a[i] !== b[i]) return 1'b0;
        return 1'b1;
    endfunction
    task automatic chkStream(input logic cmp);
        logic e0 [$];
        logic e1 [$];
        model(0, cmp, e0);
        model(1, cmp, e1);
        checks++;
        if (!same(got, e0) && !same(got, e1)) begin
            miscompares++;
            $display("BAD %0t stream differs, %0d bits", $time, got.size());
        end
    endtask
    task automatic run(input logic cmp);
        int n = 0;
        configRequest_n = 1'b0;
        compressEn = cmp;
        cyc(40);
        chk(statusOe & configCompleteOe, 1'b1, "not in reset");
        got.delete();
        configRequest_n = 1'b1;
        waitv(statusOe, 1'b0, 20);
        waitv(configCompleteOe, 1'b0, 5000);
        cyc(4);
        chkStream(cmp);
        chk(statusOut | configCompleteOut, 1'b0, "open-drain level");
        chk(fm.cmdSh === 32'h0300_0000, 1'b1, "read command");
        while (userMode !== 1'b1 && n < 2100) begin
            cyc(1);
            n++;
        end
        chk(n >= 396 && n <= 2000, 1'b1, "user mode delay");
        if (n >= 2100) end_of_test();
        $display("test configure compressed=%0d done", cmp);
    endtask
    task automatic bridge();
        bridgeEn = 1'b1;
        bridgeSelect_n = 1'b0;
        for (int k = 0; k < 32; k++) begin
            bridgeClk = k[0];
            if (!k[0]) bridgeCmd = 1'($urandom);
            cyc(4);
            chk(flashOut.clk, bridgeClk, "bridge clock");
            chk(flashOut.cmd, bridgeCmd, "bridge command");
            chk(flashOut.select_n, 1'b0, "bridge select");
        end
        chk(bridgeData, ~fm.mem[0], "bridge data");
        bridgeSelect_n = 1'b1;
        cyc(4);
        bridgeEn = 1'b0;
        $display("test bridge done");
    endtask
    task automatic err(input logic ar);
        int n = 0;
        autoRestartEn = ar;
        configRequest_n = 1'b0;
        compressEn = 1'b0;
        cyc(40);
        configRequest_n = 1'b1;
        cyc(100);
        frameError = 1'b1;
        cyc(1);
        frameError = 1'b0;
        cyc(4);
        chk(statusOe, 1'b1, "error not flagged");
        while (statusOe === 1'b1 && n < 2100) begin
            cyc(1);
            n++;
        end
        chk(n < 2000, ar, "restart timing");
        if (ar) waitv(configCompleteOe, 1'b0, 5000);
        $display("test error restart=%0d done", ar);
    endtask
    initial begin
        void'($urandom(32'h7a399cf3));
        foreach (fm.mem[k]) fm.mem[k] = 1'($urandom);
        cyc(4);
        arst_n = 1'b1;
        run(1'b0);
        bridge();
        for (int v = 0; v < 2; v++) begin
            foreach (fm.mem[k]) fm.mem[k] = v[0];
            run(1'b1);
        end
        err(1'b1);
        err(1'b0);
        configRequest_n = 1'b0;
        chipEnableIn_n = 1'b1;
        cyc(20);
        chk(flashOut.clkOe | flashOut.selectOe | flashOut.cmdOe, 1'b0, "pins driven");
        configRequest_n = 1'b1;
        cyc(20);
        chk(statusOe, 1'b1, "start while disabled");
        chipEnableIn_n = 1'b0;
        waitv(configCompleteOe, 1'b0, 5000);
        $display("test programming takeover done");
        end_of_test();
    end
endmodule // scfm_config_master_tb
`default_nettype wire
